/* File: rsrt_pkg.sv */
`default_nettype none

package rsrt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_PERIOD_NS  = 40;
    // least width of an external request on the reset pin
    localparam int RST_IN_MIN_NS  = 200;
    // least width the device drives the reset pin low after recognition
    localparam int RST_OUT_MIN_NS = 20000;
    localparam int RST_IN_CYC     = (RST_IN_MIN_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int RST_OUT_CYC    = (RST_OUT_MIN_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int CNT_W          = 13;
    localparam logic [12:0] DELAY_SHORT_CYC = 13'h0100;
    localparam logic [12:0] DELAY_LONG_CYC  = 13'h1000;
    localparam int FETCH_CYC      = 2;
    // pin must read high this long after release before the delay starts
    localparam int SETTLE_CYC     = 3;
    localparam logic SYNC_RST_VAL = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // vector and trim defaults
    localparam logic [15:0] RESET_VECTOR  = 16'hfffe;
    localparam logic [7:0]  TRIM_HIGH_RST = 8'hff;
    localparam logic [7:0]  TRIM_LOW_RST  = 8'h03;

    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses) and status fields
    localparam logic [7:0] OFS_TRIM_HIGH = 8'h00;
    localparam logic [7:0] OFS_TRIM_LOW  = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam int ST_PHASE_LSB   = 0;
    localparam int ST_PIN_DRV     = 2;
    localparam int ST_CAUSE_LSB   = 4;
    localparam int ST_CLK_SRC_LSB = 8;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        SEQ_RUN,
        SEQ_ACTIVE,
        SEQ_DELAY,
        SEQ_FETCH
    } rsrt_seq_e;

    typedef enum logic [2:0] {
        CLK_EXT,
        CLK_XTAL0,
        CLK_XTAL1,
        CLK_XTAL2,
        CLK_XTAL3,
        CLK_RC
    } rsrt_clk_src_e;

    typedef enum logic [2:0] {
        CAUSE_POWER,
        CAUSE_PIN,
        CAUSE_LVD,
        CAUSE_WDG,
        CAUSE_ILLOP
    } rsrt_cause_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } rsrt_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } rsrt_wb_rsp_s;

    typedef struct packed {
        rsrt_clk_src_e src;
        logic          ext_en;
        logic          xtal_en;
        logic          rc_en;
    } rsrt_clk_ctl_s;

endpackage

`default_nettype wire

/* File: rsrt_sync.sv */
`default_nettype none

module rsrt_sync
    import rsrt_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);

    typedef struct packed {
        logic s1;
        logic s2;
    } rsrt_sync_s;

    rsrt_sync_s state_reg;
    rsrt_sync_s state_next;

    always_comb
    begin
        state_next.s1 = d_i;
        state_next.s2 = state_reg.s1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '{s1: SYNC_RST_VAL, s2: SYNC_RST_VAL};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign q_o = state_reg.s2;

endmodule

`default_nettype wire

/* File: rsrt_downcnt.sv */
`default_nettype none

module rsrt_downcnt
    import rsrt_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] load_val_i,
    input  wire logic             en_i,
    output logic                  zero_o
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } rsrt_cnt_s;

    rsrt_cnt_s state_reg;
    rsrt_cnt_s state_next;

    always_comb
    begin
        state_next = state_reg;
        if (load_i)
        begin
            state_next.cnt = load_val_i;
        end
        else if (en_i && state_reg.cnt != '0)
        begin
            state_next.cnt = state_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign zero_o = (state_reg.cnt == '0);

endmodule

`default_nettype wire

/* File: rsrt_top.sv */
`default_nettype none

module rsrt_top
    import rsrt_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire rsrt_wb_req_s  wb_req_i,
    output rsrt_wb_rsp_s       wb_rsp_o,
    input  wire logic [2:0]    opt_clk_src_i,
    input  wire logic          opt_long_delay_i,
    input  wire logic          lvd_reset_i,
    input  wire logic          wdg_reset_i,
    input  wire logic          illegal_op_i,
    input  wire logic          rst_pin_i,
    output logic               rst_pin_o,
    output logic               rst_pin_oe_o,
    output logic               cpu_reset_o,
    output logic               vector_fetch_o,
    output logic [15:0]        vector_addr_o,
    output rsrt_clk_ctl_s      clk_ctl_o,
    output logic [9:0]         rc_trim_value_o
);

    typedef struct packed {
        rsrt_seq_e     seq;
        rsrt_cause_e   cause;
        rsrt_clk_src_e clk_src;
        logic          long_delay;
        logic [7:0]    trim_high;
        logic [1:0]    trim_low;
        logic [2:0]    filt;
        logic [1:0]    settle;
        logic          fetch_idx;
        logic          ack;
        logic [31:0]   rdata;
    } rsrt_state_s;

    rsrt_state_s state_reg;
    rsrt_state_s state_next;

    logic             pin_sync;
    logic             pin_low;
    logic             stretch_load;
    logic             stretch_zero;
    logic             delay_load;
    logic             delay_zero;
    logic [CNT_W-1:0] delay_val;
    logic             in_reset;
    logic             pin_drive;
    logic             bus_req;
    logic             any_internal;
    rsrt_cause_e      internal_cause;
    logic [31:0]      read_mux;
    rsrt_clk_src_e    opt_src;

    ////////////////////////////////////////////////////////////////////////
    // pin sampling and counters

    // the pin is sampled through two flops so that the end of an
    // outside pulse lands on a clean edge before any counting starts
    rsrt_sync u_pin_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (rst_pin_i),
        .q_o   (pin_sync)
    );

    rsrt_downcnt u_stretch
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (stretch_load),
        .load_val_i (CNT_W'(RST_OUT_CYC)),
        .en_i       (1'b1),
        .zero_o     (stretch_zero)
    );

    rsrt_downcnt u_delay
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (delay_load),
        .load_val_i (delay_val),
        .en_i       (state_reg.seq == SEQ_DELAY),
        .zero_o     (delay_zero)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers

    assign pin_low  = ~pin_sync;
    assign in_reset = (state_reg.seq == SEQ_ACTIVE)
                   || (state_reg.seq == SEQ_DELAY);
    assign bus_req  = wb_req_i.cyc & wb_req_i.stb;

    // the long option is caught while the sequence is active
    assign delay_val = state_reg.long_delay ?
                       DELAY_LONG_CYC - 1'b1 :
                       DELAY_SHORT_CYC - 1'b1;

    assign any_internal = lvd_reset_i | wdg_reset_i | illegal_op_i;

    always_comb
    begin
        // low-voltage wins: it is a level and holds the device longest
        if (lvd_reset_i)
        begin
            internal_cause = CAUSE_LVD;
        end
        else if (wdg_reset_i)
        begin
            internal_cause = CAUSE_WDG;
        end
        else
        begin
            internal_cause = CAUSE_ILLOP;
        end
    end

    // unused option codes fall back to the rc oscillator, which always
    // starts, rather than to a crystal that may be absent
    always_comb
    begin
        unique case (opt_clk_src_i)
            3'h0:    opt_src = CLK_EXT;
            3'h1:    opt_src = CLK_XTAL0;
            3'h2:    opt_src = CLK_XTAL1;
            3'h3:    opt_src = CLK_XTAL2;
            3'h4:    opt_src = CLK_XTAL3;
            3'h5:    opt_src = CLK_RC;
            default: opt_src = CLK_RC;
        endcase
    end

    always_comb
    begin
        read_mux = 32'h0000_0000;
        unique case (wb_req_i.adr)
            OFS_TRIM_HIGH:
                read_mux[7:0] = state_reg.trim_high;
            OFS_TRIM_LOW:
                read_mux[1:0] = state_reg.trim_low;
            OFS_STATUS:
            begin
                read_mux[ST_PHASE_LSB +: 2]   = state_reg.seq;
                read_mux[ST_PIN_DRV]          = pin_drive;
                read_mux[ST_CAUSE_LSB +: 3]   = state_reg.cause;
                read_mux[ST_CLK_SRC_LSB +: 3] = state_reg.clk_src;
            end
            default:
                read_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        state_next   = state_reg;
        stretch_load = 1'b0;
        delay_load   = 1'b0;

        // bus slave: ack one cycle after the request, write at the edge that ends the ack
        state_next.ack = 1'b0;
        if (bus_req && !state_reg.ack)
        begin
            state_next.ack   = 1'b1;
            state_next.rdata = read_mux;
        end
        if (bus_req && state_reg.ack && wb_req_i.we && wb_req_i.sel[0]
            && !in_reset)
        begin
            if (wb_req_i.adr == OFS_TRIM_HIGH)
            begin
                state_next.trim_high = wb_req_i.dat[7:0];
            end
            if (wb_req_i.adr == OFS_TRIM_LOW)
            begin
                // bits 7:2 are not stored and read back as zero
                state_next.trim_low = wb_req_i.dat[1:0];
            end
        end

        unique case (state_reg.seq)
            SEQ_RUN:
            begin
                // a low shorter than the least width is filtered out
                if (pin_low)
                begin
                    state_next.filt = state_reg.filt + 1'b1;
                end
                else
                begin
                    state_next.filt = '0;
                end
                if (any_internal)
                begin
                    state_next.seq   = SEQ_ACTIVE;
                    state_next.cause = internal_cause;
                    stretch_load     = 1'b1;
                end
                else if (pin_low
                         && state_reg.filt == 3'(RST_IN_CYC - 1))
                begin
                    state_next.seq   = SEQ_ACTIVE;
                    state_next.cause = CAUSE_PIN;
                    stretch_load     = 1'b1;
                end
            end
            SEQ_ACTIVE:
            begin
                state_next.filt       = '0;
                state_next.clk_src    = opt_src;
                state_next.long_delay = opt_long_delay_i;
                if (wdg_reset_i || illegal_op_i)
                begin
                    stretch_load = 1'b1;
                end
                // a long outside pulse is waited out, not stretched
                if (!stretch_zero || lvd_reset_i || pin_low)
                begin
                    state_next.settle = '0;
                end
                else if (state_reg.settle == 2'(SETTLE_CYC - 1))
                begin
                    state_next.seq = SEQ_DELAY;
                    delay_load     = 1'b1;
                end
                else
                begin
                    state_next.settle = state_reg.settle + 1'b1;
                end
            end
            SEQ_DELAY:
            begin
                // our own drive makes the pin read low: ignore it here
                if (any_internal)
                begin
                    state_next.seq   = SEQ_ACTIVE;
                    state_next.cause = internal_cause;
                    stretch_load     = 1'b1;
                end
                else if (delay_zero)
                begin
                    state_next.seq       = SEQ_FETCH;
                    state_next.fetch_idx = 1'b0;
                end
            end
            SEQ_FETCH:
            begin
                state_next.fetch_idx = 1'b1;
                if (any_internal)
                begin
                    state_next.seq   = SEQ_ACTIVE;
                    state_next.cause = internal_cause;
                    stretch_load     = 1'b1;
                end
                else if (state_reg.fetch_idx == 1'(FETCH_CYC - 1))
                begin
                    state_next.seq  = SEQ_RUN;
                    state_next.filt = '0;
                end
            end
        endcase

        // trim returns to its defaults on every reset of the device
        if (state_next.seq == SEQ_ACTIVE || state_next.seq == SEQ_DELAY)
        begin
            state_next.trim_high = TRIM_HIGH_RST;
            state_next.trim_low  = TRIM_LOW_RST[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg.seq        <= SEQ_ACTIVE;
            state_reg.cause      <= CAUSE_POWER;
            state_reg.clk_src    <= CLK_RC;
            state_reg.long_delay <= 1'b1;
            state_reg.trim_high  <= TRIM_HIGH_RST;
            state_reg.trim_low   <= TRIM_LOW_RST[1:0];
            state_reg.filt       <= '0;
            state_reg.settle     <= '0;
            state_reg.fetch_idx  <= 1'b0;
            state_reg.ack        <= 1'b0;
            state_reg.rdata      <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // open drain: the level is always low, only the enable moves; the
    // pull-up lives outside this logic
    assign pin_drive = lvd_reset_i
                    || (state_reg.seq == SEQ_DELAY)
                    || (state_reg.seq == SEQ_ACTIVE && !stretch_zero);
    assign rst_pin_o    = 1'b0;
    assign rst_pin_oe_o = pin_drive;

    assign cpu_reset_o    = in_reset;
    assign vector_fetch_o = (state_reg.seq == SEQ_FETCH);
    assign vector_addr_o  = {RESET_VECTOR[15:1],
                             state_reg.fetch_idx};

    // the chosen crystal is not stopped by a reset sequence, only rst_i forces the rc clock regardless of the option,
    // so no start-up time is lost when the sequence ends
    always_comb
    begin
        clk_ctl_o.src     = state_reg.clk_src;
        clk_ctl_o.ext_en  = (state_reg.clk_src == CLK_EXT);
        clk_ctl_o.rc_en   = (state_reg.clk_src == CLK_RC);
        clk_ctl_o.xtal_en = !clk_ctl_o.ext_en
                         && !clk_ctl_o.rc_en;
    end

    // higher code means a slower rc clock; the oscillator sees the raw
    // value
    assign rc_trim_value_o = {state_reg.trim_high,
                              state_reg.trim_low};

    assign wb_rsp_o.ack = state_reg.ack;
    assign wb_rsp_o.dat = state_reg.rdata;

    // the pin is only seen while clk_i runs: a halt mode must keep this
    // block's clock free-running for pin resets to be caught

endmodule

`default_nettype wire

/* File: rsrt_chk.sv */
`default_nettype none

module rsrt_chk
    import rsrt_pkg::*;
(
    input wire logic          clk_i,
    input wire logic          rst_i,
    input wire rsrt_wb_req_s  wb_req_i,
    input wire rsrt_wb_rsp_s  wb_rsp_o,
    input wire logic          lvd_reset_i,
    input wire logic          wdg_reset_i,
    input wire logic          illegal_op_i,
    input wire logic          rst_pin_i,
    input wire logic          rst_pin_oe_o,
    input wire logic          cpu_reset_o,
    input wire logic          vector_fetch_o,
    input wire logic [15:0]   vector_addr_o,
    input wire rsrt_clk_ctl_s clk_ctl_o,
    input wire logic [9:0]    rc_trim_value_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    // run length of the pin drive, cleared whenever the drive drops
    logic [15:0] oe_run_reg;
    logic [15:0] oe_run_next;
    logic        wb_take;

    assign wb_take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    always_comb oe_run_next = rst_pin_oe_o ? oe_run_reg + 16'h0001 : 16'h0000;
    always_ff @(posedge clk_i) oe_run_reg <= rst_i ? 16'h0000 : oe_run_next;

    sequence s_fetch_pair;
        vector_fetch_o && vector_addr_o == RESET_VECTOR ##1
        vector_fetch_o && vector_addr_o == 16'hffff ##1 !vector_fetch_o;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_ack_next: assert property (wb_take |=> wb_rsp_o.ack)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");
    a_fetch_vector: assert property (
        $rose(vector_fetch_o) |-> s_fetch_pair)
        else $error("vector fetch not two cycles at fffe and ffff");
    a_delay_count: assert property (
        $rose(vector_fetch_o) |->
        oe_run_reg == 16'h0100 || oe_run_reg == 16'h1000)
        else $error("delay phase length wrong");
    a_pin_stretch: assert property (
        $fell(rst_pin_oe_o) |->
        oe_run_reg >= (cpu_reset_o ? 16'(RST_OUT_CYC) : 16'h0100))
        else $error("pin drive released too early");
    a_lvd_drive: assert property (
        lvd_reset_i |-> rst_pin_oe_o)
        else $error("pin not driven during low-voltage reset");
    a_source_enter: assert property (
        (wdg_reset_i || illegal_op_i || lvd_reset_i) && !cpu_reset_o
        |-> ##[1:3] cpu_reset_o && rst_pin_oe_o)
        else $error("internal source did not start reset");
    a_pin_taken: assert property (
        (!rst_pin_i)[*8] |-> ##[0:2] cpu_reset_o)
        else $error("held pin low not recognised");
    a_trim_held: assert property (
        cpu_reset_o |-> rc_trim_value_o == 10'h3ff)
        else $error("trim not at default during reset");
    a_trim_write: assert property (
        wb_rsp_o.ack && wb_req_i.we && wb_req_i.adr == OFS_TRIM_HIGH
        && wb_req_i.sel[0] && !cpu_reset_o
        |=> rc_trim_value_o[9:2] == $past(wb_req_i.dat[7:0]))
        else $error("trim high write not seen in trim value");
    a_xtal_kept: assert property (
        clk_ctl_o.src inside {CLK_XTAL0, CLK_XTAL1, CLK_XTAL2, CLK_XTAL3}
        |-> clk_ctl_o.xtal_en)
        else $error("crystal oscillator stopped");
endmodule

bind rsrt_top rsrt_chk chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .lvd_reset_i(lvd_reset_i), .wdg_reset_i(wdg_reset_i),
    .illegal_op_i(illegal_op_i), .rst_pin_i(rst_pin_i),
    .rst_pin_oe_o(rst_pin_oe_o), .cpu_reset_o(cpu_reset_o),
    .vector_fetch_o(vector_fetch_o), .vector_addr_o(vector_addr_o),
    .clk_ctl_o(clk_ctl_o), .rc_trim_value_o(rc_trim_value_o)
);

`default_nettype wire

/* File: rsrt_ext_model.sv */
`default_nettype none

module rsrt_ext_model
    import rsrt_pkg::*;
(
    output logic      clk_o,
    input  wire logic hold_low_i,
    input  wire logic pin_drv_i,
    input  wire logic pin_oe_i,
    output logic      pin_level_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // outside clock source, square with even duty cycle
    initial clk_o = 1'b0;
    always #(CLK_PERIOD_NS / 2) clk_o = ~clk_o;

    // open drain: any party may sink, the weak pull-up wins otherwise
    assign pin_level_o = !(hold_low_i
                           || (pin_oe_i && !pin_drv_i));
endmodule

`default_nettype wire

/* File: test_rsrt_top.sv */
`default_nettype none

module test_rsrt_top
    import rsrt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic          clk_i, rst_i, long_dly, low_voltage_detector, wdg, illop, hold_low;
    logic          pin_lvl, pin_drv, pin_oe, cpu_rst, vfetch;
    logic [2:0]    opt_src;
    logic [15:0]   vaddr;
    logic [9:0]    trim;
    logic [31:0]   rd;
    rsrt_wb_req_s  wb_req;
    rsrt_wb_rsp_s  wb_rsp;
    rsrt_clk_ctl_s clk_ctl;
    int            err_total;
    int            check_count;
    localparam rsrt_cause_e CAUSES [5] =
        '{CAUSE_WDG, CAUSE_ILLOP, CAUSE_LVD, CAUSE_PIN, CAUSE_PIN};

    rsrt_top uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .opt_clk_src_i(opt_src), .opt_long_delay_i(long_dly),
        .lvd_reset_i(low_voltage_detector), .wdg_reset_i(wdg), .illegal_op_i(illop),
        .rst_pin_i(pin_lvl), .rst_pin_o(pin_drv), .rst_pin_oe_o(pin_oe),
        .cpu_reset_o(cpu_rst), .vector_fetch_o(vfetch),
        .vector_addr_o(vaddr), .clk_ctl_o(clk_ctl), .rc_trim_value_o(trim)
    );
    rsrt_ext_model ext (
        .clk_o(clk_i), .hold_low_i(hold_low), .pin_drv_i(pin_drv),
        .pin_oe_i(pin_oe), .pin_level_o(pin_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask

    task stop_test;
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one classic cycle; entered right after an edge, left one idle edge on
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_rsp.ack !== 1'b1 && n < 20);
        rd = wb_rsp.dat;
        if (n == 20)
            err_total++;
        wb_req <= '0;
        @(posedge clk_i);
    endtask

    task wait_run;
        int n;
        n = 0;
        while (cpu_rst !== 1'b0 && n < 9000)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 9000)
            err_total++;
        repeat (4) @(posedge clk_i);
    endtask

    // 0 watchdog, 1 illegal op, 2 low voltage, 3 short pin, 4 long pin
    task fire(input int k);
        case (k)
            0: wdg <= 1'b1;
            1: illop <= 1'b1;
            2: low_voltage_detector <= 1'b1;
            default: hold_low <= 1'b1;
        endcase
        repeat (k == 2 ? 600 : k == 3 ? RST_IN_CYC + 3 : k == 4 ? 700 : 1)
            @(posedge clk_i);
        {wdg, illop, low_voltage_detector, hold_low} <= 4'h0;
        repeat (4) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_i, long_dly, low_voltage_detector, wdg, illop, hold_low} = 6'b110000;
        opt_src = 3'h5;
        wb_req = '0;
        err_total = 0;
        check_count = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // a write during the reset phase must be dropped
        wb(1'b1, OFS_TRIM_HIGH, 32'h0000_0012);
        wb(1'b0, OFS_TRIM_HIGH, 32'h0);
        check(rd, 32'h0000_00ff);
        wb(1'b0, OFS_TRIM_LOW, 32'h0);
        check(rd, 32'h0000_0003);
        wait_run;
        long_dly <= 1'b0;
        wb(1'b1, OFS_TRIM_HIGH, 32'h0000_005a);
        wb(1'b1, OFS_TRIM_LOW, 32'h0000_00ff);
        wb(1'b0, OFS_TRIM_HIGH, 32'h0);
        check(rd, 32'h0000_005a);
        wb(1'b0, OFS_TRIM_LOW, 32'h0);
        check(rd, 32'h0000_0003);
        check(32'(trim), 32'h0000_016b);
        // a binary search starts from the middle code
        wb(1'b1, OFS_TRIM_HIGH, 32'h0000_0080);
        wb(1'b1, OFS_TRIM_LOW, 32'h0000_0000);
        check(32'(trim), 32'h0000_0200);
        wb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0); // unmapped place reads zero
        for (int k = 0; k < 6; k++)
        begin
            opt_src <= k[2:0];
            wb(1'b1, OFS_TRIM_HIGH, 32'h0000_0040);
            fire(k % 5);
            wait_run;
            check(32'(trim), 32'h0000_03ff);
            wb(1'b0, OFS_STATUS, 32'h0);
            check(rd & 32'h0000_0777,
                {21'h0, k[2:0], 1'b0, CAUSES[k % 5], 4'h0});
            check(32'(clk_ctl),
                32'({k[2:0], k == 0, k > 0 && k < 5, k == 5}));
        end
        // a power reset in the middle of a watchdog sequence takes over
        wdg <= 1'b1;
        @(posedge clk_i);
        wdg <= 1'b0;
        repeat (100) @(posedge clk_i);
        rst_i <= 1'b1;
        // three edges, so the drive that reset drops has settled
        // before the checker is enabled again
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_run;
        wb(1'b0, OFS_STATUS, 32'h0);
        check(rd & 32'h0000_0073,
            {25'h0, CAUSE_POWER, 4'h0});
        stop_test;
    end

    // whole run is about 10000 cycles; give it four times that
    initial
    begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        stop_test;
    end
endmodule

`default_nettype wire
